// ==== pkg/dtc_cfg.svh ====
// Function
// - With its enable set, each channel inverts its output on every match that raises its own request.
// - Software presets the low channel output level through output control bits 2 and 3.
// - Mode control bit 2 joins both counters into one 16-bit counter.
// - Cascaded, the low counter uses the selected clock; the high counter counts overflows.
// - Cascaded counting starts and stops with mode control bit 0.
// - Both counters matching together clear both, keep counting, raise the high request.
// - Cascaded, a low match still raises the low request and inverts the low output.
// - The 16-bit count reads in one access; software never reads it bytewise.
// - Select codes 0000 and 0001 count edges of the external event pin.
// - Select codes 0101 to 1110 give 2 to 1024 main clock periods.
// - Select code 1111 gives a period of 4096 main clock periods.
// - External counting uses rising or falling edges, chosen by the select code.
// - Separate, each counter clears on its own match and raises its own request.
`ifndef DTC_CFG_SVH
`define DTC_CFG_SVH
`define DTC_ADR_W       8
`define DTC_OFF_MODE    8'h00
`define DTC_OFF_CLKSEL  8'h04
`define DTC_OFF_OUTCTL  8'h08
`define DTC_OFF_CMPLO   8'h0C
`define DTC_OFF_CMPHI   8'h10
`define DTC_OFF_COUNT   8'h14
`define DTC_OFF_STAT    8'h18
`define DTC_OFF_MASK    8'h1C
`define DTC_MODE_CE     0
`define DTC_MODE_CASC   2
`define DTC_OUT_EN_A    0
`define DTC_OUT_RST     2
`define DTC_OUT_SET     3
`define DTC_OUT_EN_B    4
`define DTC_IRQ_LOW     0
`define DTC_IRQ_HIGH    1
`define DTC_RST_MODE    8'h00
`define DTC_RST_CLKSEL  4'h0
`define DTC_RST_OUTCTL  8'h00
`define DTC_RST_CMP     8'h00
`define DTC_RST_MASK    2'h3
`define DTC_SEL_FALL    4'h0
`define DTC_SEL_RISE    4'h1
`define DTC_SEL_INT_LO  4'h5
`define DTC_SEL_MAX     4'hF
`define DTC_SHIFT_BASE  4'h4
`define DTC_SHIFT_MAX   4'hC
`define DTC_DIV_W       12
`endif

// ==== pkg/dtc_pkg.sv ====
package dtc_pkg;
  typedef logic [7:0] dtc_byte_t;
  typedef logic [3:0] dtc_code_t;
  typedef logic [1:0] dtc_irq_t;
endpackage

// ==== pkg/dtc_tick_if.sv ====
`timescale 1ns/1ps
interface dtc_tick_if;
  dtc_pkg::dtc_code_t code;
  logic               ext_pin;
  logic               tick;
  modport src  (input code, input ext_pin, output tick);
  modport sink (output code, output ext_pin, input tick);
endinterface

// ==== rtl/dtc_prescale.sv ====
`timescale 1ns/1ps
`include "dtc_cfg.svh"
module dtc_prescale #(
  parameter int DIV_W = `DTC_DIV_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Tick source
  dtc_tick_if.src  tk
);
  logic [DIV_W-1:0] div;
  logic             ext_meta;
  logic             ext_sync;
  logic             ext_last;
  wire  [3:0]       shift;
  wire  [DIV_W-1:0] mask;
  wire              int_hit;
  wire              is_int;
  wire              rise;
  wire              fall;
  wire              next_tick;

  // Divider runs free, so a start may lose up to one period
  assign shift   = (tk.code == `DTC_SEL_MAX) ? `DTC_SHIFT_MAX :
                   4'(tk.code - `DTC_SHIFT_BASE);
  assign mask    = (DIV_W'(1) << shift) - DIV_W'(1);
  assign int_hit = ((div & mask) == mask);
  assign is_int  = (tk.code >= `DTC_SEL_INT_LO);
  assign rise    = ext_sync & ~ext_last;
  assign fall    = ~ext_sync & ext_last;
  assign next_tick = is_int ? int_hit :
                     (tk.code == `DTC_SEL_RISE) ? rise :
                     (tk.code == `DTC_SEL_FALL) ? fall : 1'b0;

  always_ff @(posedge clk) begin
    if (rst) begin
      div      <= '0;
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
      ext_last <= 1'b0;
      tk.tick  <= 1'b0;
    end else begin
      div      <= div + DIV_W'(1);
      ext_meta <= tk.ext_pin;
      ext_sync <= ext_meta;
      ext_last <= ext_sync;
      tk.tick  <= next_tick;
    end
  end
endmodule

// ==== rtl/dtc_timer_pair.sv ====
// The register offsets and the Wishbone register port were chosen for this implementation.
`timescale 1ns/1ps
`include "dtc_cfg.svh"
module dtc_timer_pair (
  // Clock and reset
  input  wire logic                 CLK_SYS,
  input  wire logic                 SYS_RST,
  // Wishbone slave
  input  wire logic                 WB_CYC_I,
  input  wire logic                 WB_STB_I,
  input  wire logic                 WB_WE_I,
  input  wire logic [`DTC_ADR_W-1:0] WB_ADR_I,
  input  wire logic [3:0]           WB_SEL_I,
  input  wire logic [31:0]          WB_DAT_I,
  output logic      [31:0]          WB_DAT_O,
  output logic                      WB_ACK_O,
  // Timer pins
  input  wire logic                 EXT_EVENT_IN,
  output logic                      TIMER_OUT_A,
  output logic                      TIMER_OUT_B,
  // Interrupt
  output logic                      IRQ
);
  dtc_tick_if tk ();

  dtc_pkg::dtc_byte_t mode_ctrl_reg;
  dtc_pkg::dtc_code_t clk_sel_reg;
  dtc_pkg::dtc_byte_t out_ctrl_reg;
  dtc_pkg::dtc_byte_t cmp_low;
  dtc_pkg::dtc_byte_t cmp_high;
  dtc_pkg::dtc_byte_t count_low;
  dtc_pkg::dtc_byte_t count_high;
  dtc_pkg::dtc_irq_t  irq_stat;
  dtc_pkg::dtc_irq_t  irq_mask;
  dtc_pkg::dtc_byte_t next_low;
  dtc_pkg::dtc_byte_t next_high;
  dtc_pkg::dtc_irq_t  next_stat;
  logic               ev_low;
  logic               ev_high;
  logic               next_out_a;
  logic               next_out_b;
  logic [31:0]        next_rdata;

  dtc_prescale #(
    .DIV_W (`DTC_DIV_W)
  ) u_prescale (
    .clk (CLK_SYS),
    .rst (SYS_RST),
    .tk  (tk.src)
  );

  assign tk.code    = clk_sel_reg;
  assign tk.ext_pin = EXT_EVENT_IN;

  // Bus decode
  wire req      = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  wire wr       = req & WB_WE_I & WB_SEL_I[0];
  wire rd       = req & ~WB_WE_I;
  wire hit_mode = (WB_ADR_I == `DTC_OFF_MODE);
  wire hit_clk  = (WB_ADR_I == `DTC_OFF_CLKSEL);
  wire hit_out  = (WB_ADR_I == `DTC_OFF_OUTCTL);
  wire hit_cmpl = (WB_ADR_I == `DTC_OFF_CMPLO);
  wire hit_cmph = (WB_ADR_I == `DTC_OFF_CMPHI);
  wire hit_cnt  = (WB_ADR_I == `DTC_OFF_COUNT);
  wire hit_stat = (WB_ADR_I == `DTC_OFF_STAT);
  wire hit_mask = (WB_ADR_I == `DTC_OFF_MASK);
  wire wr_mode  = wr & hit_mode;
  wire wr_clk   = wr & hit_clk;
  wire wr_out   = wr & hit_out;
  wire wr_cmpl  = wr & hit_cmpl;
  wire wr_cmph  = wr & hit_cmph;
  wire wr_mask  = wr & hit_mask;
  wire rd_stat  = rd & hit_stat;

  // Preset strobes act once and read back as zero
  wire preset_set = wr_out & WB_DAT_I[`DTC_OUT_SET];
  wire preset_rst = wr_out & WB_DAT_I[`DTC_OUT_RST];
  wire out_wdata_clean = 1'b0;
  wire [7:0] out_wval = {WB_DAT_I[7:4], out_wdata_clean, out_wdata_clean,
                         WB_DAT_I[1:0]};

  // Counting control
  wire run      = mode_ctrl_reg[`DTC_MODE_CE];
  wire cascade  = mode_ctrl_reg[`DTC_MODE_CASC];
  wire step     = run & tk.tick;
  wire low_hit  = (count_low == cmp_low);
  wire high_hit = (count_high == cmp_high);
  wire low_ovf  = (count_low == 8'hFF);
  wire en_a     = out_ctrl_reg[`DTC_OUT_EN_A];
  wire en_b     = out_ctrl_reg[`DTC_OUT_EN_B];

  // Counter next state
  always_comb begin
    next_low  = count_low;
    next_high = count_high;
    ev_low    = 1'b0;
    ev_high   = 1'b0;
    if (!run) begin
      // Stopping clears the count so a restart begins at zero
      next_low  = 8'h00;
      next_high = 8'h00;
    end else if (step) begin
      ev_low = low_hit;
      if (cascade) begin
        if (low_hit && high_hit) begin
          next_low  = 8'h00;
          next_high = 8'h00;
          ev_high   = 1'b1;
        end else begin
          next_low = count_low + 8'h01;
          if (low_ovf) begin
            next_high = count_high + 8'h01;
          end
        end
      end else begin
        ev_high   = high_hit;
        next_low  = low_hit ? 8'h00 : count_low + 8'h01;
        next_high = high_hit ? 8'h00 : count_high + 8'h01;
      end
    end
  end

  // Output flip-flops; a preset write wins over a toggle
  always_comb begin
    next_out_a = TIMER_OUT_A;
    if (ev_low && en_a) begin
      next_out_a = ~TIMER_OUT_A;
    end
    if (preset_set && !preset_rst) begin
      next_out_a = 1'b1;
    end else if (preset_rst && !preset_set) begin
      next_out_a = 1'b0;
    end
  end

  always_comb begin
    next_out_b = TIMER_OUT_B;
    if (ev_high && en_b) begin
      next_out_b = ~TIMER_OUT_B;
    end
  end

  // Read clears status, but a new event in that cycle survives
  assign next_stat = (rd_stat ? 2'h0 : irq_stat) | {ev_high, ev_low};

  // Read data mux
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (hit_mode) begin
      next_rdata[7:0] = mode_ctrl_reg;
    end else if (hit_clk) begin
      next_rdata[3:0] = clk_sel_reg;
    end else if (hit_out) begin
      next_rdata[7:0] = out_ctrl_reg;
    end else if (hit_cmpl) begin
      next_rdata[7:0] = cmp_low;
    end else if (hit_cmph) begin
      next_rdata[7:0] = cmp_high;
    end else if (hit_cnt) begin
      // Both bytes taken in one cycle so no carry tears the value
      next_rdata[15:0] = {count_high, count_low};
    end else if (hit_stat) begin
      next_rdata[1:0] = irq_stat;
    end else if (hit_mask) begin
      next_rdata[1:0] = irq_mask;
    end
  end

  // Bus answer
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
    end else begin
      WB_ACK_O <= req;
      WB_DAT_O <= rd ? next_rdata : 32'h0000_0000;
    end
  end

  // Control registers
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      mode_ctrl_reg <= `DTC_RST_MODE;
      clk_sel_reg   <= `DTC_RST_CLKSEL;
      out_ctrl_reg  <= `DTC_RST_OUTCTL;
    end else begin
      if (wr_mode) begin
        mode_ctrl_reg <= {5'h00, WB_DAT_I[`DTC_MODE_CASC], 1'b0,
                          WB_DAT_I[`DTC_MODE_CE]};
      end
      if (wr_clk) begin
        clk_sel_reg <= WB_DAT_I[3:0];
      end
      if (wr_out) begin
        out_ctrl_reg <= {3'h0, out_wval[4], 3'h0, out_wval[0]};
      end
    end
  end

  // Compare registers, one byte each
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      cmp_low  <= `DTC_RST_CMP;
      cmp_high <= `DTC_RST_CMP;
    end else begin
      if (wr_cmpl) begin
        cmp_low <= WB_DAT_I[7:0];
      end
      if (wr_cmph) begin
        cmp_high <= WB_DAT_I[7:0];
      end
    end
  end

  // Counters
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      count_low  <= 8'h00;
      count_high <= 8'h00;
    end else begin
      count_low  <= next_low;
      count_high <= next_high;
    end
  end

  // Timer outputs
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      TIMER_OUT_A <= 1'b0;
      TIMER_OUT_B <= 1'b0;
    end else begin
      TIMER_OUT_A <= next_out_a;
      TIMER_OUT_B <= next_out_b;
    end
  end

  // Interrupt status, mask and line; mask reset keeps both quiet
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      irq_stat <= 2'h0;
      irq_mask <= `DTC_RST_MASK;
      IRQ      <= 1'b0;
    end else begin
      irq_stat <= next_stat;
      if (wr_mask) begin
        irq_mask <= WB_DAT_I[1:0];
      end
      IRQ <= |(irq_stat & ~irq_mask);
    end
  end
endmodule

// ==== bench/dtc_ev_src.sv ====
`timescale 1ns/1ps
module dtc_ev_src (
  // Clock
  input wire logic clk,
  // Event pin, idle low
  output logic     pin
);
  initial pin = 1'b0;
  // Whole pulses only, so either edge choice sees n edges
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge clk);
      pin <= 1'b1;
      repeat (4) @(posedge clk);
      pin <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask
endmodule

// ==== bench/dtc_timer_pair_chk.sv ====
`timescale 1ns/1ps
`include "dtc_cfg.svh"
module dtc_timer_pair_chk (
  // Clock and reset
  input wire logic                  CLK_SYS,
  input wire logic                  SYS_RST,
  // Bus
  input wire logic                  WB_CYC_I,
  input wire logic                  WB_STB_I,
  input wire logic                  WB_WE_I,
  input wire logic [`DTC_ADR_W-1:0] WB_ADR_I,
  input wire logic [3:0]            WB_SEL_I,
  input wire logic [31:0]           WB_DAT_I,
  input wire logic [31:0]           WB_DAT_O,
  input wire logic                  WB_ACK_O,
  // Interrupt
  input wire logic                  IRQ
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);
  sequence req_s;
    WB_CYC_I && WB_STB_I && !WB_ACK_O;
  endsequence
  sequence rd_s;
    WB_ACK_O && !WB_WE_I;
  endsequence
  sequence mask_all_s;
    WB_ACK_O && WB_WE_I && WB_SEL_I[0] && WB_ADR_I == `DTC_OFF_MASK
      && WB_DAT_I[1:0] == 2'h3;
  endsequence
  ack_next_a: assert property (req_s |=> WB_ACK_O)
    else $error("request not answered");
  ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property ($rose(WB_ACK_O) |-> $past(WB_STB_I))
    else $error("ack without request");
  dat_idle_a: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0)
    else $error("read data outside ack");
  unmapped_zero_a: assert property (rd_s and WB_ADR_I >= 8'h20
    |-> WB_DAT_O == 32'h0) else $error("unmapped read not zero");
  count_word_a: assert property (rd_s and WB_ADR_I == `DTC_OFF_COUNT
    |-> WB_DAT_O[31:16] == 16'h0) else $error("count wider");
  stat_width_a: assert property (rd_s and WB_ADR_I == `DTC_OFF_STAT
    |-> WB_DAT_O[31:2] == 30'h0) else $error("status upper bits set");
  mask_quiet_a: assert property (mask_all_s |=> !IRQ [*2])
    else $error("masked interrupt still high");
endmodule
bind dtc_timer_pair dtc_timer_pair_chk u_chk (.CLK_SYS(CLK_SYS),
  .SYS_RST(SYS_RST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
  .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I),
  .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .IRQ(IRQ));

// ==== bench/dtc_timer_pair_tb_top.sv ====
`timescale 1ns/1ps
`include "dtc_cfg.svh"
module dtc_timer_pair_tb_top;
  logic        clk;
  logic        rst;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        ack;
  logic        ev;
  logic        out_a;
  logic        out_b;
  logic        irq;
  logic [31:0] lfsr;
  logic [31:0] q;
  int          n_mismatch;
  int          num_checks;
  int          cycles;
  int          cnt;
  int          n16;
  int          per;
  logic        oa;
  logic        ob;
  int          exp_q[$];
  int          rst_val[8] = '{0, 0, 0, 0, 0, 0, 0, 3};
  int          codes[3] = '{5, 6, 15};
  int          highs[3] = '{1, 1, 0};
  int          ev_mode[3] = '{5, 5, 1};
  int          ev_cnt[3] = '{3, 3, 32'h100};
  int          ev_st[3] = '{1, 1, 3};
  dtc_timer_pair u_dut (.CLK_SYS(clk), .SYS_RST(rst), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
    .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .EXT_EVENT_IN(ev), .TIMER_OUT_A(out_a), .TIMER_OUT_B(out_b), .IRQ(irq));
  dtc_ev_src u_ev (.clk(clk), .pin(ev));
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    next_rand = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic wrap_up;
    if (n_mismatch == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    sel  <= 4'hF;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // Edges from one output change to the next
  task automatic wait_b(output int n);
    logic b0;
    b0 = out_b;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (out_b === b0);
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 90000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  initial begin
    rst = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    wdat = 32'h0;
    lfsr = 32'h0EE6;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      wb(0, 8'(4 * i), 0);
      chk(q, rst_val[i]);
    end
    wb(0, 8'h20, 0);
    chk(q, 0);
    wb(1, `DTC_OFF_OUTCTL, 32'h08);
    @(posedge clk);
    chk(out_a, 1);
    wb(1, `DTC_OFF_OUTCTL, 32'h04);
    @(posedge clk);
    chk(out_a, 0);
    // Low request masked, as a 16-bit interval timer needs
    wb(1, `DTC_OFF_MASK, 32'h1);
    for (int k = 0; k < 3; k++) begin
      lfsr = next_rand(lfsr);
      n16 = highs[k] * 256 + int'(lfsr[3:0]);
      per = codes[k] == 15 ? 4096 : 1 << (codes[k] - 4);
      exp_q.push_back((n16 + 1) * per);
      wb(1, `DTC_OFF_MODE, 0);
      wb(1, `DTC_OFF_CMPLO, n16 & 255);
      wb(1, `DTC_OFF_CMPHI, n16 >> 8);
      wb(1, `DTC_OFF_CLKSEL, codes[k]);
      wb(1, `DTC_OFF_OUTCTL, 32'h11);
      wb(1, `DTC_OFF_MODE, 32'h5);
      wait_b(cnt);
      wait_b(cnt);
      chk(cnt, exp_q.pop_front());
      wb(0, `DTC_OFF_COUNT, 0);
      // Two cycles after the clear only the fastest rate has ticked
      chk(q, 2 / per);
      chk(irq, 1);
      wb(1, `DTC_OFF_MODE, 0);
      wb(0, `DTC_OFF_STAT, 0);
      chk(q, 3);
      wb(0, `DTC_OFF_STAT, 0);
      chk(q, 0);
      chk(irq, 0);
    end
    wb(1, `DTC_OFF_MASK, 32'h3);
    wb(1, `DTC_OFF_CMPLO, 32'h02);
    wb(1, `DTC_OFF_CMPHI, 32'h01);
    for (int k = 0; k < 3; k++) begin
      wb(1, `DTC_OFF_MODE, 0);
      wb(1, `DTC_OFF_CLKSEL, k == 0 ? 0 : 1);
      wb(1, `DTC_OFF_MODE, ev_mode[k]);
      oa = out_a;
      ob = out_b;
      u_ev.pulses(3);
      repeat (8) @(posedge clk);
      chk(out_a, oa ^ 1'b1);
      chk(out_b, ob ^ (k == 2));
      wb(0, `DTC_OFF_COUNT, 0);
      chk(q, ev_cnt[k]);
      wb(0, `DTC_OFF_STAT, 0);
      chk(q, ev_st[k]);
    end
    wrap_up();
  end
endmodule
